// ==== twe_regs.vh ====
/*
 constants for the three-wire eeprom command engine: opcodes, sub-codes,
 field widths and programming time. assumes a 100 MHz system clock.
*/
// Functional notes
// - command: start bit 1, two-bit opcode, address (9 or 8 bits), data.
// - opcode 10 read, 01 write, 11 erase; 00 uses top address sub-code.
// - width select high: 16-bit words; low: 8-bit words, longer address.
// - self-timed programming completes within ten milliseconds.
// - read output changes only on shift clock rising edges after decode.
// - a zero dummy bit precedes the first read word, msb first.
// - select held high after a word advances the pointer and continues.
// - no dummy bit between consecutive words of a sequential read.
// - programming is disabled after power-up.
// - program-enable needed first; stays enabled until program-disable.
// - erase sets every bit of the addressed location to one.
// - erase starts as soon as opcode and address are decoded.
// - write starts right after the last data bit arrives.
// - after select low then high, status is driven on serial output.
// - status reads zero while busy, one when done.
// - no status if select rises after programming ended.
// - erase-all sets every bit of the array to one.
// - write-all programs every location with the command data.
// - program-disable blocks all programming commands.
// - reads work whether programming is enabled or not.
// - small part ignores top address bit but it is still clocked.
`ifndef TWE_REGS_VH
`define TWE_REGS_VH
`define TWE_OP_SPECIAL 2'h0
`define TWE_OP_WRITE 2'h1
`define TWE_OP_READ 2'h2
`define TWE_OP_ERASE 2'h3
`define TWE_SUB_DISABLE 2'h0
`define TWE_SUB_WRALL 2'h1
`define TWE_SUB_ERALL 2'h2
`define TWE_SUB_ENABLE 2'h3
`define TWE_ADDR_BITS_X8 5'h09
`define TWE_ADDR_BITS_X16 5'h08
`define TWE_TWP_NS 10000000
`define TWE_CLK_PERIOD_NS 10
`define TWE_TWP_CYCLES (`TWE_TWP_NS / `TWE_CLK_PERIOD_NS)
`endif

// ==== twe_fifo.v ====
/*
 small flip-flop fifo with valid/ready on both sides.
 assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
module twe_fifo #(
   parameter WIDTH = 26,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clock,
   input wire rst_n,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data = mem_reg[rd_reg];
   always @(posedge clock) begin
      if (push)
         mem_reg[wr_reg] <= in_data;
      if (!rst_n) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               rd_reg + 1'b1;
         if (push && !pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule

// ==== twe_engine.v ====
/*
 command engine of a three-wire serial eeprom: decodes commands shifted in
 on serial_in, returns read data, runs self-timed programming from a queue.
 assumes select, shift_clock, serial_in and word_width_select arrive from
 outside this clock domain; shift clock is far slower than clock.
*/
`timescale 1ns/10ps
`include "twe_regs.vh"
module twe_engine #(
   parameter TWP_CYCLES = `TWE_TWP_CYCLES,
   parameter SMALL_PART = 1'b0,
   parameter QDEPTH = 8
) (
   input wire clock,
   input wire rst_n,
   input wire select,
   input wire shift_clock,
   input wire serial_in,
   input wire word_width_select,
   output reg serial_out,
   output reg serial_out_oe
);
   localparam S_IDLE = 3'h0;
   localparam S_OP = 3'h1;
   localparam S_ADDR = 3'h2;
   localparam S_DATA = 3'h3;
   localparam S_READ = 3'h4;
   localparam S_DONE = 3'h5;
   // queue entry: kind(2) width(1) addr(9) data(16); the width is taken at
   // enqueue so a later organisation change cannot misplace the data
   localparam QW = 28;
   localparam K_WRITE = 2'h0;
   localparam K_WRALL = 2'h1;
   localparam K_ERASE = 2'h2;
   localparam K_ERALL = 2'h3;

   reg [2:0] sel_sync_reg;
   reg [2:0] sk_sync_reg;
   reg [1:0] di_sync_reg;
   reg [1:0] org_sync_reg;
   reg [2:0] state_reg;
   reg [4:0] cnt_reg;
   reg [1:0] op_reg;
   reg [8:0] addr_reg;
   reg [15:0] data_reg;
   reg [15:0] shout_reg;
   reg wide_reg;
   reg enable_reg;
   reg status_arm_reg;
   reg [15:0] mem_reg [0:511];
   reg busy_reg;
   reg [31:0] twp_reg;
   integer i;
   reg [QW-1:0] cur_reg;
   reg q_valid;
   reg [QW-1:0] q_data;

   wire sel = sel_sync_reg[1];
   wire sel_rise = sel_sync_reg[1] && !sel_sync_reg[2];
   wire sk_rise = sk_sync_reg[1] && !sk_sync_reg[2];
   wire di = di_sync_reg[1];
   wire wide = org_sync_reg[1];
   wire q_ready;
   wire [QW-1:0] h_data;
   wire h_valid;
   wire h_ready = !busy_reg;
   wire [8:0] a_mask = SMALL_PART ? (wide_reg ? 9'h07f : 9'h0ff) : 9'h1ff;
   wire [4:0] addr_len = wide_reg ? `TWE_ADDR_BITS_X16 : `TWE_ADDR_BITS_X8;
   wire [4:0] data_len = wide_reg ? 5'h10 : 5'h08;
   wire [8:0] addr_next = {addr_reg[7:0], di};
   wire [1:0] sub = wide_reg ? addr_next[7:6] : addr_next[8:7];
   wire [15:0] data_next = {data_reg[14:0], di};
   // programming in flight or still queued counts as busy for status
   wire prog_busy = busy_reg || h_valid || q_valid;

   // word index of an address in the active organisation
   function [8:0] widx;
      input [8:0] a;
      input w;
      begin
         widx = w ? {1'b0, a[7:0]} : {1'b0, a[8:1]};
      end
   endfunction

   function [15:0] rd_word;
      input [15:0] word;
      input lo;
      input w;
      begin
         if (w)
            rd_word = word;
         else
            rd_word = lo ? {word[7:0], 8'h00} : {word[15:8], 8'h00};
      end
   endfunction

   twe_fifo #(
      .WIDTH(QW),
      .DEPTH(QDEPTH),
      .AW(3)
   ) u_queue (
      .clock(clock),
      .rst_n(rst_n),
      .in_data(q_data),
      .in_valid(q_valid),
      .in_ready(q_ready),
      .out_data(h_data),
      .out_valid(h_valid),
      .out_ready(h_ready)
   );

   always @(posedge clock) begin
      if (!rst_n) begin
         sel_sync_reg <= 3'h0;
         sk_sync_reg <= 3'h0;
         di_sync_reg <= 2'h0;
         org_sync_reg <= 2'h0;
      end else begin
         sel_sync_reg <= {sel_sync_reg[1:0], select};
         sk_sync_reg <= {sk_sync_reg[1:0], shift_clock};
         di_sync_reg <= {di_sync_reg[0], serial_in};
         org_sync_reg <= {org_sync_reg[0], word_width_select};
      end
   end

   // command decoder; a full queue stalls the enqueue by holding q_valid
   always @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         cnt_reg <= 5'h00;
         op_reg <= 2'h0;
         addr_reg <= 9'h000;
         data_reg <= 16'h0000;
         shout_reg <= 16'h0000;
         wide_reg <= 1'b1;
         enable_reg <= 1'b0;
         status_arm_reg <= 1'b0;
         q_valid <= 1'b0;
         q_data <= {QW{1'b0}};
         serial_out <= 1'b0;
         serial_out_oe <= 1'b0;
      end else begin
         if (q_valid && q_ready)
            q_valid <= 1'b0;
         if (!sel) begin
            state_reg <= S_IDLE;
            cnt_reg <= 5'h00;
            serial_out_oe <= 1'b0;
            serial_out <= 1'b0;
         end else if (sel_rise) begin
            wide_reg <= wide;
            // status only if programming still runs at this rise
            if (status_arm_reg && prog_busy) begin
               serial_out_oe <= 1'b1;
               serial_out <= 1'b0;
            end
            status_arm_reg <= 1'b0;
         end else begin
            if (serial_out_oe && state_reg == S_IDLE && cnt_reg == 5'h00)
               serial_out <= !prog_busy;
            if (sk_rise) begin
               case (state_reg)
                  S_IDLE: begin
                     if (di) begin
                        state_reg <= S_OP;
                        cnt_reg <= 5'h00;
                        serial_out_oe <= 1'b0;
                     end
                  end
                  S_OP: begin
                     op_reg <= {op_reg[0], di};
                     if (cnt_reg == 5'h01) begin
                        state_reg <= S_ADDR;
                        cnt_reg <= 5'h00;
                     end else
                        cnt_reg <= cnt_reg + 5'h01;
                  end
                  S_ADDR: begin
                     addr_reg <= addr_next;
                     if (cnt_reg == addr_len - 5'h01) begin
                        cnt_reg <= 5'h00;
                        case (op_reg)
                           `TWE_OP_READ: begin
                              state_reg <= S_READ;
                              serial_out_oe <= 1'b1;
                              serial_out <= 1'b0;
                              shout_reg <= rd_word(mem_reg[widx(addr_next
                                 & a_mask, wide_reg)], addr_next[0],
                                 wide_reg);
                           end
                           `TWE_OP_WRITE:
                              state_reg <= S_DATA;
                           `TWE_OP_ERASE: begin
                              state_reg <= S_DONE;
                              if (enable_reg) begin
                                 q_valid <= 1'b1;
                                 q_data <= {K_ERASE, wide_reg,
                                    addr_next & a_mask,
                                    16'hffff};
                                 status_arm_reg <= 1'b1;
                              end
                           end
                           default: begin
                              state_reg <= S_DONE;
                              case (sub)
                                 `TWE_SUB_ENABLE:
                                    enable_reg <= 1'b1;
                                 `TWE_SUB_DISABLE:
                                    enable_reg <= 1'b0;
                                 `TWE_SUB_ERALL: begin
                                    if (enable_reg) begin
                                       q_valid <= 1'b1;
                                       q_data <= {K_ERALL, wide_reg, 9'h000,
                                          16'hffff};
                                       status_arm_reg <= 1'b1;
                                    end
                                 end
                                 default:
                                    state_reg <= S_DATA;
                              endcase
                           end
                        endcase
                     end else
                        cnt_reg <= cnt_reg + 5'h01;
                  end
                  S_DATA: begin
                     data_reg <= data_next;
                     if (cnt_reg == data_len - 5'h01) begin
                        state_reg <= S_DONE;
                        if (enable_reg) begin
                           q_valid <= 1'b1;
                           q_data <= {(op_reg == `TWE_OP_WRITE) ?
                              K_WRITE : K_WRALL, wide_reg, addr_reg & a_mask,
                              wide_reg ? data_next :
                              {data_next[7:0], 8'h00}};
                           status_arm_reg <= 1'b1;
                        end
                     end else
                        cnt_reg <= cnt_reg + 5'h01;
                  end
                  S_READ: begin
                     serial_out <= shout_reg[15];
                     if (cnt_reg == data_len - 5'h01) begin
                        cnt_reg <= 5'h00;
                        addr_reg <= (addr_reg + 9'h001) & a_mask;
                        // next word loads back to back, no dummy bit
                        shout_reg <= rd_word(mem_reg[widx((addr_reg +
                           9'h001) & a_mask, wide_reg)], !addr_reg[0],
                           wide_reg);
                     end else begin
                        cnt_reg <= cnt_reg + 5'h01;
                        shout_reg <= {shout_reg[14:0], 1'b0};
                     end
                  end
                  default:
                     state_reg <= S_DONE;
               endcase
            end
         end
      end
   end

   // self-timed programming; time fixed at the maximum so it never exceeds it
   always @(posedge clock) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
         twp_reg <= 32'h0;
         cur_reg <= {QW{1'b0}};
      end else if (!busy_reg) begin
         if (h_valid) begin
            busy_reg <= 1'b1;
            cur_reg <= h_data;
            twp_reg <= 32'h0;
         end
      end else if (twp_reg == TWP_CYCLES - 1) begin
         busy_reg <= 1'b0;
         twp_reg <= 32'h0;
         // whole-array kinds land in one cycle, so they fit the same bound
         if (cur_reg[QW-2]) begin
            for (i = 0; i < 512; i = i + 1)
               mem_reg[i] <= cur_reg[QW-3] ? cur_reg[15:0] :
                  {cur_reg[15:8], cur_reg[15:8]};
         end else if (cur_reg[QW-3])
            mem_reg[widx(cur_reg[24:16], 1'b1)] <= cur_reg[15:0];
         else if (cur_reg[16])
            mem_reg[widx(cur_reg[24:16], 1'b0)][7:0] <=
               cur_reg[15:8];
         else
            mem_reg[widx(cur_reg[24:16], 1'b0)][15:8] <= cur_reg[15:8];
      end else
         twp_reg <= twp_reg + 32'h1;
   end
endmodule

// ==== twe_engine_sva.sv ====
/*
 port checker for the eeprom command engine.
 assumes a bind from tb_top and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module twe_chk #(
   parameter TWP_CYCLES = 64,
   parameter QDEPTH = 8
) (
   input wire clock,
   input wire rst_n,
   input wire select,
   input wire shift_clock,
   input wire serial_in,
   input wire word_width_select,
   input wire serial_out,
   input wire serial_out_oe
);
   localparam int LIMIT = TWP_CYCLES * (QDEPTH + 2);
   reg sk_q;
   reg [3:0] sk_age;
   reg [3:0] lo_age;
   reg [31:0] busy_cnt;
   wire sk_rise = shift_clock && !sk_q;
   // ages saturate at 15: only "recent or long ago" matters
   always @(posedge clock) begin
      if (!rst_n) begin
         sk_q <= 1'b0;
         sk_age <= 4'hf;
         lo_age <= 4'hf;
         busy_cnt <= 32'h0;
      end else begin
         sk_q <= shift_clock;
         sk_age <= sk_rise ? 4'h0 : sk_age + {3'h0, sk_age != 4'hf};
         lo_age <= !select ? 4'h0 : lo_age + {3'h0, lo_age != 4'hf};
         busy_cnt <= (serial_out_oe && !serial_out && !sk_rise) ?
            busy_cnt + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   reset_quiet_a: assert property ($rose(rst_n)
      |-> !serial_out_oe && !serial_out)
      else $error("outputs not quiet after reset");
   hiz_deselect_a: assert property ((!select) [*6]
      |-> !serial_out_oe)
      else $error("output driven while deselected");
   oe_start_a: assert property ($rose(serial_out_oe)
      |-> lo_age <= 4'h8 || sk_age <= 4'h8)
      else $error("output enabled without select or clock edge");
   oe_stop_a: assert property ($fell(serial_out_oe)
      |-> lo_age <= 4'h8 || sk_age <= 4'h8)
      else $error("output released without cause");
   dummy_zero_a: assert property (
      $rose(serial_out_oe) && lo_age > 4'h8 |-> !serial_out)
      else $error("read does not open with a zero bit");
   fall_on_edge_a: assert property ($fell(serial_out) &&
      serial_out_oe && $past(serial_out_oe) |-> sk_age <= 4'h8)
      else $error("output fell away from a shift clock rise");
   ready_hold_a: assert property (serial_out_oe && serial_out &&
      select && sk_age > 4'h8 |=> serial_out)
      else $error("ready or data bit dropped between edges");
   busy_bound_a: assert property (busy_cnt < LIMIT)
      else $error("busy status lasts too long");
endmodule

// ==== twe_host.sv ====
/*
 host model on the far side of the engine: select, shift clock, serial in.
 assumes the 100 MHz bench clock; shift clock period is 160 ns.
*/
`timescale 1ns/10ps
module twe_host #(
   parameter LIM = 40000
) (
   input wire clock,
   input wire serial_out,
   input wire serial_out_oe,
   output reg select,
   output reg shift_clock,
   output reg serial_in
);
   initial begin
      select = 1'b0;
      shift_clock = 1'b0;
      serial_in = 1'b0;
   end
   task wt(input integer n);
      begin
         repeat (n) @(posedge clock);
         #1;
      end
   endtask
   // the data line toggles while idle so a stale level never reads as valid
   task idle;
      begin
         select = 1'b0;
         serial_in = ~serial_in;
         wt(30);
      end
   endtask
   // n bits of v msb first, then nr filler bits; every output sample in rd
   task frame(input [63:0] v, input integer n, input integer nr,
      output [63:0] rd);
      integer i;
      begin
         rd = 64'h0;
         select = 1'b1;
         wt(4);
         for (i = n + nr - 1; i >= 0; i = i - 1) begin
            serial_in = (i >= nr) ? v[i - nr] : ~serial_in;
            wt(8);
            shift_clock = 1'b1;
            wt(8);
            rd = {rd[62:0], serial_out};
            shift_clock = 1'b0;
         end
         idle;
      end
   endtask
   task status(output f, output integer w);
      begin
         select = 1'b1;
         wt(6);
         f = serial_out_oe ? serial_out : 1'b1;
         w = 0;
         while (!(serial_out_oe === 1'b1 && serial_out === 1'b1) &&
            w < LIM) begin
            wt(1);
            w = w + 1;
         end
         idle;
      end
   endtask
endmodule

// ==== tb_top.sv ====
/*
 self-checking bench for the eeprom command engine driven by a host model.
 assumes twe_engine, twe_host and twe_chk are compiled before this file.
*/
`timescale 1ns/10ps
`include "twe_regs.vh"
module tb_top;
   localparam TWP = 64;
   reg clock;
   reg rst_n;
   reg word_width_select;
   wire select, shift_clock, serial_in, serial_out, serial_out_oe;
   integer err_total;
   integer checks;
   integer k;
   reg [15:0] lf;
   reg [15:0] mem [0:255];
   reg [63:0] rd;
   reg [7:0] base;
   twe_engine #(.TWP_CYCLES(TWP)) i_dut (
      .clock(clock), .rst_n(rst_n), .select(select),
      .shift_clock(shift_clock), .serial_in(serial_in),
      .word_width_select(word_width_select), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe));
   twe_host #(.LIM(40000)) i_host (.clock(clock), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .select(select),
      .shift_clock(shift_clock), .serial_in(serial_in));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // in byte mode an even address is the high half of a word
   function [15:0] expect_at(input [8:0] a);
      if (word_width_select)
         expect_at = mem[a[7:0]];
      else
         expect_at = {8'h0, a[0] ? mem[a[8:1]][7:0] : mem[a[8:1]][15:8]};
   endfunction
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task finish_test;
      begin
         if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task op(input [1:0] o, input [8:0] a, input [15:0] d, input integer nr);
      reg [63:0] v;
      integer aw, dw, n;
      begin
         aw = word_width_select ? 8 : 9;
         dw = word_width_select ? 16 : 8;
         v = ((64'h4 | o) << aw) | ({55'h0, a} & ((64'h1 << aw) - 64'h1));
         n = 3 + aw;
         if (o == `TWE_OP_WRITE || (o == `TWE_OP_SPECIAL &&
            a[aw - 2 +: 2] == `TWE_SUB_WRALL)) begin
            v = (v << dw) | ({48'h0, d} & ((64'h1 << dw) - 64'h1));
            n = n + dw;
         end
         i_host.frame(v, n, nr, rd);
      end
   endtask
   task spec(input [1:0] sub);
      op(`TWE_OP_SPECIAL, word_width_select ? {1'b0, sub, 6'h0} :
         {sub, 7'h0}, 16'h0, 0);
   endtask
   task prog(input [1:0] o, input [8:0] a, input [15:0] d, input integer mw);
      reg f;
      integer w;
      begin
         op(o, a, d, 0);
         i_host.status(f, w);
         chk("busy status", 16'h0, {15'h0, f});
         chk("ready in time", 16'h1, {15'h0, w <= mw});
      end
   endtask
   task rdchk(input [8:0] a, input integer nw);
      reg [63:0] t;
      integer dw, j;
      begin
         dw = word_width_select ? 16 : 8;
         op(`TWE_OP_READ, a, 16'h0, nw * dw);
         chk("dummy bit", 16'h0, {15'h0, rd[nw * dw]});
         for (j = 0; j < nw; j = j + 1) begin
            t = (rd >> ((nw - 1 - j) * dw)) & ((64'h1 << dw) - 64'h1);
            chk("read data", expect_at(a + j), t[15:0]);
         end
      end
   endtask
   initial begin
      err_total = 0;
      checks = 0;
      lf = 16'h7dfe;
      word_width_select = 1'b1;
      rst_n = 1'b0;
      repeat (6) @(posedge clock);
      #1;
      rst_n = 1'b1;
      i_host.wt(3);
      spec(`TWE_SUB_ENABLE);
      prog(`TWE_OP_SPECIAL, {1'b0, `TWE_SUB_WRALL, 6'h0}, 16'h5a3c,
         512 * TWP);
      for (k = 0; k < 256; k = k + 1)
         mem[k] = 16'h5a3c;
      rdchk(9'h9, 1);
      rst_n = 1'b0;
      i_host.wt(6);
      rst_n = 1'b1;
      i_host.wt(3);
      op(`TWE_OP_WRITE, 9'h9, 16'h1234, 0);
      op(`TWE_OP_ERASE, 9'ha, 16'h0, 0);
      rdchk(9'h9, 2);
      spec(`TWE_SUB_ENABLE);
      base = {2'h0, lf[5:0]} + 8'h10;
      for (k = 0; k < 3; k = k + 1) begin
         lf = lfsr(lf);
         mem[base + k] = lf;
         prog(`TWE_OP_WRITE, {1'b0, base + k[7:0]}, lf, TWP);
      end
      rdchk({1'b0, base}, 3);
      prog(`TWE_OP_ERASE, {1'b0, base + 8'h1}, 16'h0, TWP);
      mem[base + 1] = 16'hffff;
      rdchk({1'b0, base}, 2);
      spec(`TWE_SUB_DISABLE);
      op(`TWE_OP_WRITE, {1'b0, base}, ~mem[base], 0);
      rdchk({1'b0, base}, 1);
      word_width_select = 1'b0;
      rdchk({base, 1'b0}, 2);
      spec(`TWE_SUB_ENABLE);
      lf = lfsr(lf);
      mem[base][7:0] = lf[7:0];
      prog(`TWE_OP_WRITE, {base, 1'b1}, lf, TWP);
      rdchk({base, 1'b0}, 4);
      word_width_select = 1'b1;
      prog(`TWE_OP_SPECIAL, {1'b0, `TWE_SUB_ERALL, 6'h0}, 16'h0,
         512 * TWP);
      for (k = 0; k < 256; k = k + 1)
         mem[k] = 16'hffff;
      lf = lfsr(lf);
      rdchk({1'b0, lf[7:0]}, 2);
      spec(`TWE_SUB_DISABLE);
      finish_test;
   end
   // the scenarios need roughly 10600 cycles; this leaves ample margin
   initial begin
      repeat (50000) @(posedge clock);
      err_total = err_total + 1;
      finish_test;
   end
endmodule
bind twe_engine twe_chk #(.TWP_CYCLES(TWP_CYCLES), .QDEPTH(QDEPTH)) i_chk (
   .clock(clock), .rst_n(rst_n), .select(select), .shift_clock(shift_clock),
   .serial_in(serial_in), .word_width_select(word_width_select),
   .serial_out(serial_out), .serial_out_oe(serial_out_oe));
